// ===== design/i2cm_pkg.sv
package i2cm_pkg;

	localparam int          CLK_PERIOD_NS = 10;
	localparam int          SCL_PERIOD_NS = 10000;
	localparam int          QUARTER_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int          CNT_W         = 12;
	localparam logic [3:0]  ACK_BIT       = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_START     = 4'h1,
		ST_LOW       = 4'h2,
		ST_RISE      = 4'h3,
		ST_HIGH      = 4'h4,
		ST_HOLD      = 4'h5,
		ST_STOP_LOW  = 4'h6,
		ST_STOP_RISE = 4'h7,
		ST_STOP_HIGH = 4'h8,
		ST_RS_LOW    = 4'h9,
		ST_RS_RISE   = 4'hA
	} i2cm_state_t;

	typedef struct packed {
		logic       start;
		logic       stop;
		logic       read;
		logic       ack;
		logic [7:0] data;
	} i2cm_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic       ack;
		logic       arb_lost;
	} i2cm_rsp_t;

endpackage

// ===== design/i2cm_master.sv
`timescale 1ns/10ps
`default_nettype none

module i2cm_master #(
	parameter int QUARTER = i2cm_pkg::QUARTER_CYC
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              cmd_valid,
	output var  logic              cmd_ready,
	input  wire i2cm_pkg::i2cm_cmd_t cmd,
	output var  logic              rsp_valid,
	output var  i2cm_pkg::i2cm_rsp_t rsp,
	output var  logic              bus_busy,
	input  wire logic              scl_i,
	output var  logic              scl_o,
	output var  logic              scl_oe_n,
	input  wire logic              sda_i,
	output var  logic              sda_o,
	output var  logic              sda_oe_n
);

	localparam int CW = i2cm_pkg::CNT_W;
	localparam logic [CW-1:0] Q_M1    = CW'(QUARTER - 1);
	localparam logic [CW-1:0] HALF_M1 = CW'(2 * QUARTER - 1);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and bus condition monitor

	logic scl_m_r;
	logic sda_m_r;
	logic scl_s_r;
	logic sda_s_r;
	logic scl_q_r;
	logic sda_q_r;
	logic low_seen_r;
	logic busy_r;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			scl_m_r <= 1'h1;
			sda_m_r <= 1'h1;
			scl_s_r <= 1'h1;
			sda_s_r <= 1'h1;
			scl_q_r <= 1'h1;
			sda_q_r <= 1'h1;
		end
		else
		begin
			scl_m_r <= scl_i;
			sda_m_r <= sda_i;
			scl_s_r <= scl_m_r;
			sda_s_r <= sda_m_r;
			scl_q_r <= scl_s_r;
			sda_q_r <= sda_s_r;
		end
	end

	wire scl_hi    = scl_s_r & scl_q_r;
	wire start_det = scl_hi & sda_q_r & ~sda_s_r;
	// A glitch pair with SCL high never counts as Stop
	wire stop_det  = scl_hi & ~sda_q_r & sda_s_r & low_seen_r;
	wire busy_nxt  = start_det | (busy_r & ~stop_det);
	wire low_nxt   = ~start_det & (low_seen_r | ~scl_s_r);

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			busy_r     <= 1'h0;
			low_seen_r <= 1'h0;
		end
		else
		begin
			busy_r     <= busy_nxt;
			low_seen_r <= low_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transfer engine

	i2cm_pkg::i2cm_state_t state_r;
	i2cm_pkg::i2cm_state_t state_nxt;
	logic [CW-1:0]         cnt_r;
	logic [CW-1:0]         cnt_nxt;
	logic [3:0]            bit_r;
	logic [3:0]            bit_nxt;
	logic [7:0]            data_r;
	logic [7:0]            data_nxt;
	logic                  rd_r;
	logic                  ack_out_r;
	logic                  stop_r;
	logic                  scl_oe_n_r;
	logic                  scl_n;
	logic                  sda_oe_n_r;
	logic                  sda_n;
	logic                  ready_r;
	logic                  rsp_valid_r;
	logic                  rsp_v;
	i2cm_pkg::i2cm_rsp_t   rsp_r;
	i2cm_pkg::i2cm_rsp_t   rsp_n;

	wire take      = cmd_valid & ready_r;
	wire is_ack    = (bit_r == i2cm_pkg::ACK_BIT);
	// Acknowledge slot: transmitter lets go, receiving master answers
	wire tx_bit    = is_ack ? (rd_r ? ~ack_out_r : 1'h1)
	                        : (rd_r ? 1'h1 : data_r[7]);
	wire we_drive  = is_ack ? rd_r : ~rd_r;
	wire arb_lost  = (state_r == i2cm_pkg::ST_RISE) & scl_s_r & we_drive
	               & sda_oe_n_r & ~sda_s_r;
	wire cnt_half  = (cnt_r == HALF_M1);
	wire cnt_qtr   = (cnt_r == Q_M1);
	wire ready_nxt = ((state_nxt == i2cm_pkg::ST_IDLE) & ~busy_nxt)
	               | (state_nxt == i2cm_pkg::ST_HOLD);

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + 1'b1;
		bit_nxt   = bit_r;
		data_nxt  = data_r;
		scl_n     = scl_oe_n_r;
		sda_n     = sda_oe_n_r;
		rsp_v     = 1'h0;
		rsp_n     = rsp_r;
		unique case (state_r)
		i2cm_pkg::ST_IDLE:
		begin
			cnt_nxt = '0;
			scl_n   = 1'h1;
			sda_n   = 1'h1;
			// Every message opens with a Start; the first byte's direction follows cmd.read
			if (take)
			begin
				state_nxt = i2cm_pkg::ST_START;
				sda_n     = 1'h0;
				data_nxt  = cmd.data;
			end
		end
		i2cm_pkg::ST_HOLD:
		begin
			cnt_nxt = '0;
			if (take)
			begin
				data_nxt  = cmd.data;
				bit_nxt   = '0;
				state_nxt = cmd.start ? i2cm_pkg::ST_RS_LOW
				                      : i2cm_pkg::ST_LOW;
			end
		end
		i2cm_pkg::ST_START:
		begin
			if (cnt_half)
			begin
				scl_n     = 1'h0;
				cnt_nxt   = '0;
				bit_nxt   = '0;
				state_nxt = i2cm_pkg::ST_LOW;
			end
		end
		i2cm_pkg::ST_LOW:
		begin
			if (cnt_qtr)
				sda_n = tx_bit;
			if (cnt_half)
			begin
				scl_n     = 1'h1;
				cnt_nxt   = '0;
				state_nxt = i2cm_pkg::ST_RISE;
			end
		end
		i2cm_pkg::ST_RISE:
		begin
			cnt_nxt = '0;
			// Released SCL may still be held by a stretching slave
			if (arb_lost)
			begin
				scl_n          = 1'h1;
				sda_n          = 1'h1;
				state_nxt      = i2cm_pkg::ST_IDLE;
				rsp_v          = 1'h1;
				rsp_n.arb_lost = 1'h1;
				rsp_n.ack      = 1'h0;
				rsp_n.data     = data_r;
			end
			else if (scl_s_r)
			begin
				state_nxt = i2cm_pkg::ST_HIGH;
				if (is_ack)
				begin
					rsp_n.ack      = ~sda_s_r;
					rsp_n.data     = data_r;
					rsp_n.arb_lost = 1'h0;
				end
				else
					data_nxt = {data_r[6:0], sda_s_r};
			end
		end
		i2cm_pkg::ST_HIGH:
		begin
			if (cnt_half)
			begin
				scl_n   = 1'h0;
				cnt_nxt = '0;
				if (is_ack)
				begin
					rsp_v     = 1'h1;
					state_nxt = stop_r ? i2cm_pkg::ST_STOP_LOW
					                   : i2cm_pkg::ST_HOLD;
				end
				else
				begin
					bit_nxt   = bit_r + 1'b1;
					state_nxt = i2cm_pkg::ST_LOW;
				end
			end
		end
		i2cm_pkg::ST_STOP_LOW:
		begin
			if (cnt_qtr)
				sda_n = 1'h0;
			if (cnt_half)
			begin
				scl_n     = 1'h1;
				cnt_nxt   = '0;
				state_nxt = i2cm_pkg::ST_STOP_RISE;
			end
		end
		i2cm_pkg::ST_STOP_RISE:
		begin
			cnt_nxt = '0;
			if (scl_s_r)
				state_nxt = i2cm_pkg::ST_STOP_HIGH;
		end
		i2cm_pkg::ST_STOP_HIGH:
		begin
			if (cnt_half)
			begin
				sda_n     = 1'h1;
				state_nxt = i2cm_pkg::ST_IDLE;
			end
		end
		i2cm_pkg::ST_RS_LOW:
		begin
			if (cnt_qtr)
				sda_n = 1'h1;
			if (cnt_half)
			begin
				scl_n     = 1'h1;
				cnt_nxt   = '0;
				state_nxt = i2cm_pkg::ST_RS_RISE;
			end
		end
		i2cm_pkg::ST_RS_RISE:
		begin
			cnt_nxt = scl_s_r ? cnt_r + 1'b1 : '0;
			if (cnt_half)
			begin
				sda_n     = 1'h0;
				cnt_nxt   = '0;
				state_nxt = i2cm_pkg::ST_START;
			end
		end
		default:
		begin
			scl_n     = 1'h1;
			sda_n     = 1'h1;
			state_nxt = i2cm_pkg::ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_r     <= i2cm_pkg::ST_IDLE;
			cnt_r       <= '0;
			bit_r       <= '0;
			data_r      <= '0;
			scl_oe_n_r  <= 1'h1;
			sda_oe_n_r  <= 1'h1;
			ready_r     <= 1'h0;
			rsp_valid_r <= 1'h0;
			rsp_r       <= '0;
		end
		else
		begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			bit_r       <= bit_nxt;
			data_r      <= data_nxt;
			scl_oe_n_r  <= scl_n;
			sda_oe_n_r  <= sda_n;
			ready_r     <= ready_nxt;
			rsp_valid_r <= rsp_v;
			rsp_r       <= rsp_n;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rd_r      <= 1'h0;
			ack_out_r <= 1'h0;
			stop_r    <= 1'h0;
		end
		else if (take)
		begin
			rd_r      <= cmd.read;
			ack_out_r <= cmd.ack;
			stop_r    <= cmd.stop;
		end
	end

	// Pins only ever pull low; release is done by the enable
	assign scl_o     = 1'h0;
	assign sda_o     = 1'h0;
	assign scl_oe_n  = scl_oe_n_r;
	assign sda_oe_n  = sda_oe_n_r;
	assign cmd_ready = ready_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp       = rsp_r;
	assign bus_busy  = busy_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_sda_change;
		($changed(sda_oe_n_r) && scl_oe_n_r && $past(scl_oe_n_r))
			|-> (state_r == i2cm_pkg::ST_START
			|| state_r == i2cm_pkg::ST_IDLE);
	endproperty
	a_sda_change: assert property (p_sda_change)
		else $error("SDA moved while SCL high outside Start or Stop");

	property p_no_start_busy;
		(state_r == i2cm_pkg::ST_IDLE && take) |-> !busy_r;
	endproperty
	a_no_start_busy: assert property (p_no_start_busy)
		else $error("Start issued while bus busy");

	property p_arb_release;
		arb_lost |=> (sda_oe_n_r && scl_oe_n_r && rsp_valid_r
			&& rsp_r.arb_lost && state_r == i2cm_pkg::ST_IDLE);
	endproperty
	a_arb_release: assert property (p_arb_release)
		else $error("Lines not released after arbitration loss");

	property p_stretch;
		(state_r == i2cm_pkg::ST_RISE && !scl_s_r && !arb_lost)
			|=> (state_r == i2cm_pkg::ST_RISE);
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("Engine ran on while SCL held low");

	property p_msb_first;
		(state_r == i2cm_pkg::ST_LOW && cnt_qtr && !is_ack && !rd_r)
			|=> (sda_oe_n_r == $past(data_r[7]));
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("Data bit is not the top bit of the byte");

	property p_ack_release;
		(state_r == i2cm_pkg::ST_HIGH && is_ack && !rd_r) |-> sda_oe_n_r;
	endproperty
	a_ack_release: assert property (p_ack_release)
		else $error("Transmitter held SDA during acknowledge");

	property p_master_ack;
		(state_r == i2cm_pkg::ST_HIGH && is_ack && rd_r)
			|-> (sda_oe_n_r == !ack_out_r);
	endproperty
	a_master_ack: assert property (p_master_ack)
		else $error("Receiving master gave wrong acknowledge");

	property p_stop_seq;
		(state_r == i2cm_pkg::ST_STOP_HIGH && cnt_half)
			|-> (!sda_oe_n_r && scl_oe_n_r) ##1 (sda_oe_n_r && scl_oe_n_r);
	endproperty
	a_stop_seq: assert property (p_stop_seq)
		else $error("Stop not SDA rising under high SCL");

	property p_rsp_pulse;
		rsp_valid_r |=> !rsp_valid_r;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse)
		else $error("Answer strobe longer than one cycle");

	c_write_ack: cover property (rsp_valid_r && rsp_r.ack && !rd_r);
	c_arb_lost:  cover property (arb_lost);
	c_restart:   cover property (state_r == i2cm_pkg::ST_RS_RISE
		&& state_nxt == i2cm_pkg::ST_START);
	c_stretch:   cover property (state_r == i2cm_pkg::ST_RISE && !scl_s_r
		##8 state_r == i2cm_pkg::ST_RISE);

endmodule

`default_nettype wire

// ===== bench/i2cm_slave_model.sv
`timescale 1ns/10ps
`default_nettype none

// Acks any address; sends rd_byte, then the inverse of each byte sent
module i2cm_slave_model (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic [7:0] stretch,
	input  wire logic [7:0] rd_byte,
	output var  logic       scl_oe_n,
	output var  logic       sda_oe_n,
	output var  logic [7:0] rx_byte
);
	logic            scl_q, sda_q, addr, tx;
	logic [3:0]      bitc;
	logic [7:0]      sr, txb, wait_c;
	wire logic [7:0] nb = addr ? rd_byte : ~txb;

	assign scl_oe_n = (wait_c == 8'h00);

	always @(posedge core_clk)
	begin
		scl_q <= scl;
		sda_q <= sda;
		if (wait_c != 8'h00)
			wait_c <= wait_c - 8'h01;
		if (rst)
		begin
			sda_oe_n <= 1'b1;
			wait_c <= 8'h00;
			tx <= 1'b0;
		end
		else if (scl && scl_q && sda_q && !sda)
		begin
			bitc <= 4'h0;
			addr <= 1'b1;
			tx <= 1'b0;
			sda_oe_n <= 1'b1;
		end
		else if (scl && scl_q && !sda_q && sda)
			sda_oe_n <= 1'b1;
		else if (scl && !scl_q)
		begin
			bitc <= bitc + 4'h1;
			if (bitc < 4'h8)
				sr <= {sr[6:0], sda};
			else if (tx && sda)
				tx <= 1'b0;
		end
		else if (!scl && scl_q)
		begin
			wait_c <= stretch;
			if (bitc == 4'h8)
			begin
				sda_oe_n <= tx;
				rx_byte <= sr;
				if (addr)
					tx <= sr[0];
			end
			else if (bitc == 4'h9)
			begin
				bitc <= 4'h0;
				addr <= 1'b0;
				txb <= nb;
				sda_oe_n <= !tx || nb[7];
			end
			else if (tx && bitc != 4'h0)
				sda_oe_n <= txb[3'h7 - bitc[2:0]];
		end
	end
endmodule

`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic                core_clk = 1'b0;
	logic                rst = 1'b1;
	logic                cmd_valid = 1'b0;
	i2cm_pkg::i2cm_cmd_t cmd = '0;
	i2cm_pkg::i2cm_rsp_t rsp;
	logic                cmd_ready, rsp_valid, bus_busy, m_scl_n, m_sda_n;
	logic                scl_o, scl_oe_n, sda_o, sda_oe_n;
	logic                rv_scl_n = 1'b1, rv_sda_n = 1'b1;
	logic [7:0]          stretch = 8'h00, rd_byte = 8'h00, rx_byte, a, d, e;
	integer              seed = 32'h393A;
	int                  fail_count = 0, total_checks = 0;
	// Pull-ups win unless some agent pulls low
	wire logic           scl = (scl_oe_n | scl_o) & m_scl_n & rv_scl_n;
	wire logic           sda = (sda_oe_n | sda_o) & m_sda_n & rv_sda_n;

	always #5 core_clk = ~core_clk;

	i2cm_master #(.QUARTER(5)) i2cm_master_i (
		.core_clk, .rst, .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp,
		.bus_busy, .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda), .sda_o,
		.sda_oe_n
	);

	i2cm_slave_model i2cm_slave_model_i (
		.core_clk, .rst, .scl, .sda, .stretch, .rd_byte,
		.scl_oe_n(m_scl_n), .sda_oe_n(m_sda_n), .rx_byte
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input bit ok, input string m);
		total_checks++;
		if (!ok)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d, failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Bounded wait; running out ends the run
	task automatic await(ref logic s, input logic v);
		int n;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (s !== v && n < 4000);
		if (s !== v)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			end_sim;
		end
	endtask

	// Flags are start, stop, read, ack
	task automatic xfer(input logic [3:0] f, input logic [7:0] dt);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd <= {f, dt};
		await(cmd_ready, 1'b1);
		cmd_valid <= 1'b0;
		await(rsp_valid, 1'b1);
	endtask

	task automatic rival_stop;
		rv_scl_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		rv_sda_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		rv_scl_n <= 1'b1;
		repeat (10) @(posedge core_clk);
		rv_sda_n <= 1'b1;
	endtask

	function automatic logic [7:0] ab(input logic [6:0] x, input logic r);
		return {x, r};
	endfunction

	function automatic i2cm_pkg::i2cm_rsp_t er(input logic [7:0] x,
		input logic k);
		return {x, k, 1'b0};
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge core_clk);
		chk(scl_oe_n === 1'b1 && sda_oe_n === 1'b1, "reset");
		chk(scl_o === 1'b0 && sda_o === 1'b0, "drive level");
		rst <= 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			a = (k == 2) ? 8'h00 : 8'($random(seed));
			d = (k == 2) ? 8'hFF : 8'($random(seed));
			e = 8'($random(seed));
			stretch <= k[0] ? 8'h14 : 8'h00;
			rd_byte <= e;
			xfer(4'h8, ab(a[6:0], 1'b0));
			chk(rsp === er(ab(a[6:0], 1'b0), 1'b1), "waddr");
			xfer({1'b0, k[0], 2'b00}, d);
			chk(rsp === er(d, 1'b1) && rx_byte === d, "wdata");
			xfer(4'h8, ab(a[6:0], 1'b1));
			chk(rsp === er(ab(a[6:0], 1'b1), 1'b1), "raddr");
			xfer(4'h3, 8'h00);
			chk(rsp === er(e, 1'b1), "rdata");
			xfer(4'h6, 8'h00);
			chk(rsp === er(~e, 1'b0), "rlast");
			await(bus_busy, 1'b0);
		end
		// A rival start, then SDA back up with SCL never low
		rv_sda_n <= 1'b0;
		await(bus_busy, 1'b1);
		rv_sda_n <= 1'b1;
		repeat (12) @(posedge core_clk);
		chk(bus_busy === 1'b1, "false stop");
		cmd_valid <= 1'b1;
		cmd <= {4'h8, 8'hA0};
		repeat (20) @(posedge core_clk);
		chk(cmd_ready !== 1'b1 && sda_oe_n === 1'b1, "busy start");
		rival_stop;
		await(cmd_ready, 1'b1);
		cmd_valid <= 1'b0;
		await(sda_oe_n, 1'b0);
		rv_sda_n <= 1'b0;
		await(rsp_valid, 1'b1);
		chk(rsp.arb_lost === 1'b1, "arb loss");
		repeat (4) @(posedge core_clk);
		chk(scl_oe_n === 1'b1 && sda_oe_n === 1'b1, "loser lines");
		repeat (20) @(posedge core_clk);
		chk(cmd_ready !== 1'b1 && bus_busy === 1'b1, "loser waits");
		rival_stop;
		await(bus_busy, 1'b0);
		await(cmd_ready, 1'b1);
		end_sim;
	end
endmodule

`default_nettype wire
